/* logic/pidc_ctrl.sv */
/*
 * pidc_ctrl: page / page-interleave dram controller core with mode
 * registers, gated address bit 20, fast reset and pipelining handshake.
 * assumes: cpu inputs synchronous to clk; clk is the double-rate clock;
 * the processor phase clock and 7 MHz clock arrive as sampled inputs.
 */
// Strobed register access was decided locally.
// What this block does
// RQ1: powers up legacy until config two bit 0 written high
// RQ2: legacy page hits take zero waits
// RQ3: legacy size and banks from four straps
// RQ4: legacy miss waits from two straps
// RQ5: software writes only config two and the system port in legacy
// RQ6: cfg1 low bits 00 plus cfg2 bit0 page
// RQ7: cfg1 low bits 01 plus cfg2 bit0 interleave
// RQ8: programmable modes: straps are data, shadow ignored
// RQ9: interleave: local address pins become bank cas
// RQ10: programmable modes drive address buffer enable low
// RQ11: gated bit 20 low unless gate high
// RQ12: state machine on double-rate clock, phase input
// RQ13: ras time-out counted on 7 MHz clock
// RQ14: data direction low read, high write
// RQ15: ready one clock after next-address request
// RQ16: port bit zero drives fast reset low
// RQ17: low-megabyte select for accesses below 1M
// RQ18: local decode low during on-board transfers
// RQ19: single column strobe in non-interleaved modes
// RQ20: four row strobes, one per bank
// RQ21: byte high enable steers interleaved cas
// RQ22: hold acknowledge floats slot-side addresses outside interleave mode
// RQ23: next-address request for pipelining
// RQ24: page miss: ras high three clocks
// RQ25: page is 2KB or 4KB by part
// RQ26: refresh: all ras low, cas high
// RQ27: config writes take effect next cycle; the mode follows the cycle after next
`timescale 1ns/100ps
module pidc_ctrl (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [9:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire pidc_pkg::pidc_cpu_t cpu,
    input  wire logic              processor_phase_clock,
    input  wire logic              ras_timeout_clock,
    input  wire logic              refresh_n,
    input  wire logic [9:0]        refresh_addr,
    input  wire logic              hold_acknowledge,
    input  wire logic              external_master_n,
    input  wire logic [3:0]        size_strap_or_data_low,
    input  wire logic              wait_strap_one_or_data4,
    input  wire logic              wait_strap_two_or_data5,
    input  wire logic              shadow_enable_n,
    input  wire logic              addr_bit20_gate,
    input  wire logic              processor_addr_bit20,
    output logic                   gated_local_addr_bit20,
    output logic      [5:0]        local_addr_out,
    output logic      [5:0]        local_addr_oe,
    output logic                   column_strobe_or_bank0_lo,
    output logic                   bank0_hi_column_strobe,
    output logic      [3:0]        bank_row_strobes_n,
    output logic      [9:0]        dram_address_bus,
    output logic                   addr_buffer_enable_n,
    output logic                   memory_data_direction,
    output logic                   local_ready_n,
    output logic                   next_address_request_n,
    output logic                   fast_reset_n,
    output logic                   low_megabyte_select_n,
    output logic                   local_dram_decode_n,
    output logic                   shadow_active
);
    logic                  rst_s1;
    logic                  rst_s2;
    pidc_pkg::pidc_state_t s_q;
    pidc_pkg::pidc_state_t s_d;
    logic                  prog;
    logic                  p1m;
    logic [12:0]           row_now;
    logic [1:0]            bank_now;
    logic                  hit;
    logic                  hitw_zero;
    logic [1:0]            miss_waits;
    logic [1:0]            hit_waits;
    logic [3:0]            size_code;
    logic                  decode;

    // reset release through two flops; async assert only takes constants
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // mode-dependent decode helpers
    always_comb begin
        prog       = (s_q.mode != pidc_pkg::PIDC_LEGACY);
        // size code: straps in legacy, register bits once programmable [RQ3] [RQ8]
        size_code  = prog ? s_q.cfg_two[7:4] : size_strap_or_data_low;
        p1m        = |(size_code & pidc_pkg::SIZE_1M_MASK);
        // page size follows dram depth [RQ25]
        row_now    = p1m ? {1'b0, cpu.addr[23:pidc_pkg::PAGE_SHIFT_1M]}
                         : cpu.addr[23:pidc_pkg::PAGE_SHIFT_256K];
        bank_now   = size_code[1:0] & cpu.addr[21:20];
        hit        = s_q.open && !s_q.ras_exp && (row_now == s_q.open_row)
                     && (bank_now == s_q.open_bank);
        // miss waits from straps in legacy, register otherwise [RQ4]
        miss_waits = prog ? s_q.cfg_one[pidc_pkg::CFG1_MISSW_LO +: 2]
                          : {~wait_strap_two_or_data5, ~wait_strap_one_or_data4};
        // legacy hits never wait [RQ2]
        hit_waits  = prog ? s_q.cfg_one[pidc_pkg::CFG1_HITW_LO +: 2] : 2'b00;
        hitw_zero  = (hit_waits == 2'b00);
        decode     = !cpu.ads_n && cpu.mio && (s_q.st == pidc_pkg::PIDC_IDLE);
    end

    // next-state: registers, ras time-out, cycle sequencer
    always_comb begin
        s_d        = s_q;
        s_d.rdata  = 8'h00;
        s_d.clk7_q = ras_timeout_clock;
        // register port; offsets other than the three read zero
        if (reg_wr) begin
            // config written now, mode applied from the cycle after next [RQ27]
            if (reg_addr == pidc_pkg::ADDR_CFG_ONE && prog) begin
                s_d.cfg_one = reg_wdata;
            end
            // of the config registers, only config two is honoured while legacy [RQ5]
            if (reg_addr == pidc_pkg::ADDR_CFG_TWO) begin
                s_d.cfg_two = reg_wdata;
            end
            if (reg_addr == pidc_pkg::ADDR_SYS_PORT) begin
                s_d.sys_port = reg_wdata;
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                pidc_pkg::ADDR_CFG_ONE:  s_d.rdata = s_q.cfg_one;
                pidc_pkg::ADDR_CFG_TWO:  s_d.rdata = s_q.cfg_two;
                pidc_pkg::ADDR_SYS_PORT: s_d.rdata = s_q.sys_port;
                default:                 s_d.rdata = 8'h00;
            endcase
        end
        // mode select from both config registers [RQ1] [RQ6] [RQ7]
        if (!s_q.cfg_two[pidc_pkg::CFG2_PROG_BIT]) begin
            s_d.mode = pidc_pkg::PIDC_LEGACY;
        end else if (!s_q.cfg_one[pidc_pkg::CFG1_RSVD_BIT]
                     && s_q.cfg_one[pidc_pkg::CFG1_INTLV_BIT]) begin
            s_d.mode = pidc_pkg::PIDC_INTLV;
        end else begin
            s_d.mode = pidc_pkg::PIDC_PAGE;
        end
        // ras time-out: count rising edges of the 7 MHz input [RQ13]
        if (ras_timeout_clock && !s_q.clk7_q && s_q.open) begin
            if (s_q.ras_to == pidc_pkg::RAS_TO_MAX) begin
                s_d.ras_exp = 1'b1;
            end else begin
                s_d.ras_to = 4'(s_q.ras_to + 4'h1);
            end
        end
        // processor phase sampled each double-rate clock [RQ12]
        s_d.phase = {s_q.phase[0], processor_phase_clock};
        s_d.dram.cas_n = 8'hFF;
        case (s_q.st)
            pidc_pkg::PIDC_IDLE: begin
                s_d.busy = 1'b0;
                if (!refresh_n) begin
                    s_d.st = pidc_pkg::PIDC_REFR;
                end else if (decode) begin
                    s_d.busy       = 1'b1;
                    s_d.wr         = cpu.wr;
                    s_d.in_low_meg = (cpu.addr < pidc_pkg::ONE_MEG);
                    s_d.bank       = bank_now;
                    s_d.bhe_n      = cpu.bhe_n;
                    s_d.a0         = cpu.addr[0];
                    s_d.col        = cpu.addr[10:1];
                    s_d.dram.ma    = row_now[9:0];
                    if (hit) begin
                        s_d.cnt = hit_waits;
                        s_d.st  = hitw_zero ? pidc_pkg::PIDC_NA : pidc_pkg::PIDC_WAIT;
                    end else begin
                        // close the row and precharge before the new one [RQ24]
                        s_d.dram.ras_n = 4'hF;
                        s_d.open       = 1'b0;
                        s_d.cnt        = 2'b00;
                        s_d.st         = pidc_pkg::PIDC_PRECH;
                    end
                end
            end
            pidc_pkg::PIDC_PRECH: begin
                if (s_q.cnt == pidc_pkg::PRE_MAX) begin
                    // reopen and remember the row [RQ24] [RQ20]
                    s_d.dram.ras_n[s_q.bank] = 1'b0;
                    s_d.open      = 1'b1;
                    s_d.open_bank = s_q.bank;
                    s_d.open_row  = row_now;
                    s_d.ras_to    = 4'h0;
                    s_d.ras_exp   = 1'b0;
                    s_d.cnt       = miss_waits;
                    s_d.st        = pidc_pkg::PIDC_WAIT;
                end else begin
                    s_d.cnt = 2'(s_q.cnt + 2'b01);
                end
            end
            pidc_pkg::PIDC_WAIT: begin
                s_d.dram.ma = s_q.col;
                if (s_q.cnt == 2'b00) begin
                    s_d.st = pidc_pkg::PIDC_NA;
                end else begin
                    s_d.cnt = 2'(s_q.cnt - 2'b01);
                end
            end
            pidc_pkg::PIDC_NA: begin
                s_d.dram.ma = s_q.col;
                // column strobe: single line, or per bank and byte lane [RQ19] [RQ21]
                if (s_q.mode == pidc_pkg::PIDC_INTLV) begin
                    s_d.dram.cas_n[{s_q.bank, 1'b0}] = !(!s_q.a0);
                    s_d.dram.cas_n[{s_q.bank, 1'b1}] = s_q.bhe_n;
                end else begin
                    s_d.dram.cas_n[0] = 1'b0;
                end
                s_d.st = pidc_pkg::PIDC_RDY;
            end
            pidc_pkg::PIDC_RDY: begin
                s_d.st = pidc_pkg::PIDC_IDLE;
            end
            pidc_pkg::PIDC_REFR: begin
                // all rows strobed, cas held high, bus ignored [RQ26]
                s_d.dram.ras_n = 4'h0;
                s_d.dram.ma    = refresh_addr;
                s_d.open       = 1'b0;
                if (refresh_n) begin
                    s_d.dram.ras_n = 4'hF;
                    s_d.st         = pidc_pkg::PIDC_IDLE;
                end
            end
            default: begin
                s_d.st = pidc_pkg::PIDC_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            s_q           <= '0;
            s_q.cfg_one   <= pidc_pkg::CFG_RESET;
            s_q.cfg_two   <= pidc_pkg::CFG_RESET;
            s_q.sys_port  <= pidc_pkg::SYS_RESET;
            s_q.mode      <= pidc_pkg::PIDC_LEGACY;
            s_q.st        <= pidc_pkg::PIDC_IDLE;
            s_q.dram.ras_n <= 4'hF;
            s_q.dram.cas_n <= 8'hFF;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; pin roles change with mode
    always_comb begin
        reg_rdata              = s_q.rdata;
        // gate forces bit 20 low [RQ11]
        gated_local_addr_bit20 = processor_addr_bit20 & addr_bit20_gate;
        bank_row_strobes_n     = s_q.dram.ras_n;                     // [RQ20]
        dram_address_bus       = s_q.dram.ma;
        // external buffer carries upper address in programmable modes [RQ10]
        addr_buffer_enable_n   = !prog;
        if (s_q.mode == pidc_pkg::PIDC_INTLV) begin
            // shared pins are bank 1..3 cas, always driven [RQ9]
            local_addr_out = s_q.dram.cas_n[7:2];
            local_addr_oe  = 6'h3F;
        end else begin
            local_addr_out = {cpu.addr[23:21], cpu.addr[19:17]};
            // floated while another master owns the bus [RQ22]
            local_addr_oe  = (hold_acknowledge || !external_master_n) ? 6'h00 : 6'h3F;
        end
        column_strobe_or_bank0_lo = s_q.dram.cas_n[0];              // [RQ19]
        bank0_hi_column_strobe    = (s_q.mode == pidc_pkg::PIDC_INTLV)
                                    ? s_q.dram.cas_n[1] : 1'b1;
        memory_data_direction  = s_q.wr;                            // [RQ14]
        // next address first, ready one clock later [RQ23] [RQ15]
        next_address_request_n = (s_q.st != pidc_pkg::PIDC_RDY);
        local_ready_n          = !(s_q.st == pidc_pkg::PIDC_IDLE && s_q.busy);
        fast_reset_n           = !s_q.sys_port[pidc_pkg::SYS_FRST_BIT];  // [RQ16]
        low_megabyte_select_n  = !(s_q.busy && s_q.in_low_meg);      // [RQ17]
        local_dram_decode_n    = !s_q.busy;                          // [RQ18]
        // shadow input only counts in legacy [RQ8]
        shadow_active          = !prog && !shadow_enable_n;
    end
endmodule

/* logic/pidc_pkg.sv */
/*
 * pidc_pkg: constants, register map, mode and state types for the page
 * interleave dram controller.
 * assumes: one 125 MHz clock; register offsets are port indexes.
 */
package pidc_pkg;
    // register indexes; not all multiples of four, so byte address is four times index
    localparam logic [7:0] IDX_CFG_ONE   = 8'h12;
    localparam logic [7:0] IDX_CFG_TWO   = 8'h13;
    localparam logic [7:0] IDX_SYS_PORT  = 8'h92;
    localparam logic [9:0] ADDR_CFG_ONE  = {IDX_CFG_ONE, 2'b00};
    localparam logic [9:0] ADDR_CFG_TWO  = {IDX_CFG_TWO, 2'b00};
    localparam logic [9:0] ADDR_SYS_PORT = {IDX_SYS_PORT, 2'b00};
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] SYS_RESET     = 8'h00;
    // field positions
    localparam int CFG1_INTLV_BIT = 0;
    localparam int CFG1_RSVD_BIT  = 1;
    localparam int CFG2_PROG_BIT  = 0;
    localparam int SYS_FRST_BIT   = 0;
    localparam int CFG1_WAYS_BIT  = 2;   // never read; the bank count comes from the size code
    localparam int CFG1_HITW_LO   = 4;   // programmed page-hit waits
    localparam int CFG1_MISSW_LO  = 6;   // programmed page-miss waits
    // timing
    localparam int CLK_MHZ          = 125;
    localparam int RAS_PRECHARGE_2X = 3;     // double-rate clocks with ras high on miss
    localparam int RAS_TO_TICKS     = 8;     // ras time-out in 7 MHz ticks
    localparam logic [3:0] RAS_TO_MAX = 4'(RAS_TO_TICKS - 1);
    localparam logic [1:0] PRE_MAX    = 2'(RAS_PRECHARGE_2X - 1);
    localparam logic [23:0] ONE_MEG   = 24'h100000;
    localparam int PAGE_SHIFT_256K  = 11;    // 2KB page
    localparam int PAGE_SHIFT_1M    = 12;    // 4KB page
    localparam logic [3:0] SIZE_1M_MASK = 4'h4;  // size code bit marking 1M parts

    typedef enum logic [1:0] {PIDC_LEGACY, PIDC_PAGE, PIDC_INTLV} pidc_mode_t;
    typedef enum logic [2:0] {PIDC_IDLE, PIDC_PRECH, PIDC_WAIT, PIDC_NA, PIDC_RDY,
                              PIDC_REFR} pidc_st_t;

    // cpu request group
    typedef struct packed {
        logic        ads_n;
        logic        mio;
        logic        wr;
        logic [23:0] addr;
        logic        bhe_n;
    } pidc_cpu_t;

    // dram strobe group
    typedef struct packed {
        logic [3:0] ras_n;
        logic [7:0] cas_n;   // bank*2 + byte; index 0 is legacy single cas
        logic [9:0] ma;
    } pidc_dram_t;

    typedef struct packed {
        logic [7:0] cfg_one;
        logic [7:0] cfg_two;
        logic [7:0] sys_port;
        logic [7:0] rdata;
        pidc_mode_t mode;
        pidc_st_t   st;
        logic [1:0] phase;
        logic [1:0] cnt;
        logic [3:0] ras_to;
        logic       ras_exp;
        logic       clk7_q;
        logic       open;
        logic [1:0] open_bank;
        logic [12:0] open_row;
        logic       wr;
        logic       in_low_meg;
        logic [1:0] bank;
        logic       bhe_n;
        logic       a0;
        logic [9:0] col;
        logic       busy;
        pidc_dram_t dram;
    } pidc_state_t;
endpackage

/* bench/pidc_chk.sv */
/* pidc_chk: port-level assertions for pidc_ctrl.
   assumes: bound to pidc_ctrl; one clock domain, raw rst_b as disable. */
`timescale 1ns/100ps
module pidc_chk (
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic [9:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire pidc_pkg::pidc_cpu_t cpu,
    input wire logic                refresh_n,
    input wire logic                addr_bit20_gate,
    input wire logic                processor_addr_bit20,
    input wire logic                gated_local_addr_bit20,
    input wire logic [3:0]          bank_row_strobes_n,
    input wire logic                addr_buffer_enable_n,
    input wire logic                memory_data_direction,
    input wire logic                local_ready_n,
    input wire logic                next_address_request_n,
    input wire logic                fast_reset_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // end of a local cycle: one-cycle request, then one-cycle ready
    sequence s_pipe;
        !next_address_request_n ##1 (next_address_request_n && !local_ready_n) ##1 local_ready_n;
    endsequence
    sequence s_start;
        !cpu.ads_n && cpu.mio && refresh_n && next_address_request_n && local_ready_n;
    endsequence
    property p_pipe;
        $fell(next_address_request_n) |-> s_pipe;
    endproperty
    property p_rdy_cause;
        $fell(local_ready_n) |-> !$past(next_address_request_n);
    endproperty
    // bound chosen above the longest miss that the straps allow
    property p_ads;
        s_start |-> ##[1:20] !next_address_request_n;
    endproperty
    property p_a20;
        gated_local_addr_bit20 == (processor_addr_bit20 & addr_bit20_gate);
    endproperty
    property p_frst;
        reg_wr && reg_addr == pidc_pkg::ADDR_SYS_PORT |=> fast_reset_n != $past(reg_wdata[0]);
    endproperty
    property p_refr;
        !refresh_n [*4] |-> bank_row_strobes_n == 4'h0;
    endproperty
    property p_dir;
        !next_address_request_n |-> memory_data_direction == cpu.wr;
    endproperty
    property p_abuf;
        reg_wr && reg_addr == pidc_pkg::ADDR_CFG_TWO
            |-> ##3 addr_buffer_enable_n == !$past(reg_wdata[0], 3);
    endproperty
    a_pipe: assert property (p_pipe) else $error("ready does not follow next-address");
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready without request");
    a_ads: assert property (p_ads) else $error("memory cycle never answered");
    a_a20: assert property (p_a20) else $error("gated bit 20 wrong");
    a_frst: assert property (p_frst) else $error("fast reset not from port bit 0");
    a_refr: assert property (p_refr) else $error("row strobes not low in refresh");
    a_dir: assert property (p_dir) else $error("data direction wrong");
    a_abuf: assert property (p_abuf) else $error("buffer enable not by mode");
endmodule

/* bench/pidc_cpu_model.sv */
/* pidc_cpu_model: processor side of the local bus; one memory cycle per go
   pulse, held until ready; also makes the phase and 7 MHz clocks.
   assumes: go only while idle; clk is the 125 MHz double-rate clock. */
`timescale 1ns/100ps
module pidc_cpu_model (
    input  wire logic           clk,
    input  wire logic           go,
    input  wire logic           go_wr,
    input  wire logic [23:0]    go_addr,
    input  wire logic           local_ready_n,
    output pidc_pkg::pidc_cpu_t cpu,
    output logic                processor_phase_clock,
    output logic                ras_timeout_clock,
    output logic                busy,
    output int                  lat
);
    int div;
    initial begin
        cpu = '{1'b1, 1'b0, 1'b0, 24'hFFFFFF, 1'b1};
        busy = 1'b0;
        lat = 0;
        div = 0;
        processor_phase_clock = 1'b0;
        ras_timeout_clock = 1'b0;
    end
    // phase clock is clk halved; a 9-cycle half period gives about 7 MHz
    always @(posedge clk) begin
        processor_phase_clock <= ~processor_phase_clock;
        div <= (div == 8) ? 0 : div + 1;
        if (div == 8)
            ras_timeout_clock <= ~ras_timeout_clock;
    end
    // one-cycle start strobe; released lines show inverted values, not stale ones
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            lat <= 0;
            cpu <= '{1'b0, 1'b1, go_wr, go_addr, 1'b0};
        end else if (busy) begin
            cpu.ads_n <= 1'b1;
            lat <= lat + 1;
            if (!local_ready_n) begin
                busy <= 1'b0;
                cpu <= '{1'b1, 1'b0, ~cpu.wr, ~cpu.addr, 1'b1};
            end
        end
    end
endmodule

/* bench/tb.sv */
/* tb: directed bench for pidc_ctrl driven through a cpu bus model.
   assumes: 8 ns clock; package, design, model and checker compiled first. */
`timescale 1ns/100ps
module tb;
    logic clk, rst_b, reg_wr, reg_rd, refresh_n, hold_acknowledge, external_master_n;
    logic wait_strap_one_or_data4, wait_strap_two_or_data5, shadow_enable_n, addr_bit20_gate;
    logic processor_addr_bit20, gated_local_addr_bit20, column_strobe_or_bank0_lo;
    logic bank0_hi_column_strobe, addr_buffer_enable_n, memory_data_direction, local_ready_n;
    logic next_address_request_n, fast_reset_n, low_megabyte_select_n, local_dram_decode_n;
    logic shadow_active, processor_phase_clock, ras_timeout_clock, go, go_wr, busy;
    logic [9:0]          reg_addr, refresh_addr, dram_address_bus;
    logic [7:0]          reg_wdata, reg_rdata;
    logic [3:0]          size_strap_or_data_low, bank_row_strobes_n;
    logic [5:0]          local_addr_oe, local_addr_out;
    logic [4:0]          seen;
    logic [23:0]         go_addr;
    pidc_pkg::pidc_cpu_t cpu;
    int                  lat, n_fail, cmp_count;

    pidc_ctrl dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu,
        .processor_phase_clock, .ras_timeout_clock, .refresh_n, .refresh_addr,
        .hold_acknowledge, .external_master_n, .size_strap_or_data_low,
        .wait_strap_one_or_data4, .wait_strap_two_or_data5, .shadow_enable_n,
        .addr_bit20_gate, .processor_addr_bit20, .gated_local_addr_bit20,
        .local_addr_out, .local_addr_oe, .column_strobe_or_bank0_lo,
        .bank0_hi_column_strobe, .bank_row_strobes_n, .dram_address_bus,
        .addr_buffer_enable_n, .memory_data_direction, .local_ready_n,
        .next_address_request_n, .fast_reset_n, .low_megabyte_select_n,
        .local_dram_decode_n, .shadow_active);
    pidc_cpu_model u_cpu (.clk, .go, .go_wr, .go_addr, .local_ready_n, .cpu,
        .processor_phase_clock, .ras_timeout_clock, .busy, .lat);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // sticky marks of {any ras, low meg, decode, cas hi, cas lo}, cleared per access
    always @(posedge clk) seen <= go ? 5'h00 : seen | ~{&bank_row_strobes_n,
        low_megabyte_select_n, local_dram_decode_n, bank0_hi_column_strobe,
        column_strobe_or_bank0_lo};

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic acc(input logic [23:0] a, input logic w);
        @(posedge clk);
        go <= 1'b1;
        go_addr <= a;
        go_wr <= w;
        @(posedge clk);
        go <= 1'b0;
        repeat (60) begin
            @(posedge clk);
            if (!busy) return;
        end
        chk(32'h0, 32'h1);
    endtask
    task automatic t_regs;
        rd(pidc_pkg::ADDR_CFG_TWO, 8'h00);
        rd(10'h3FC, 8'h00);
        chk(addr_buffer_enable_n, 1'b1);
    endtask
    task automatic t_frst;
        rd(pidc_pkg::ADDR_SYS_PORT, 8'h00);
        chk(fast_reset_n, 1'b1);
        wr(pidc_pkg::ADDR_SYS_PORT, 8'h01);
        chk(fast_reset_n, 1'b0);
        rd(pidc_pkg::ADDR_SYS_PORT, 8'h01);
        wr(pidc_pkg::ADDR_SYS_PORT, 8'h00);
        chk(fast_reset_n, 1'b1);
    endtask
    task automatic t_pins;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {addr_bit20_gate, processor_addr_bit20} <= 2'(i);
            @(posedge clk);
            #1 chk(gated_local_addr_bit20, i == 3);
        end
        @(posedge clk) hold_acknowledge <= 1'b1;
        external_master_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(local_addr_oe, 6'h00);
        hold_acknowledge <= 1'b0;
        external_master_n <= 1'b1;
    endtask
    task automatic t_refresh;
        @(posedge clk);
        refresh_addr <= 10'h2A5;
        refresh_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(dram_address_bus, 10'h2A5);
        chk(column_strobe_or_bank0_lo, 1'b1);
        @(posedge clk) refresh_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    // straps at both-high give zero miss waits, both-low three
    task automatic t_legacy;
        int m, h;
        {wait_strap_two_or_data5, wait_strap_one_or_data4} <= 2'b11;
        acc(24'h000000, 1'b0);
        acc(24'h000800, 1'b0);
        m = lat;
        acc(24'h000802, 1'b1);
        h = lat;
        chk(m - h, 4);
        size_strap_or_data_low <= 4'h4;
        acc(24'h000000, 1'b0);
        acc(24'h000800, 1'b0);
        chk(lat, h);
        {wait_strap_two_or_data5, wait_strap_one_or_data4} <= 2'b00;
        acc(24'h001000, 1'b1);
        chk(lat, m + 3);
        repeat (200) @(posedge clk);
        acc(24'h001002, 1'b0);
        chk(lat, m + 3);
    endtask
    task automatic t_modes;
        shadow_enable_n <= 1'b0;
        acc(24'h000004, 1'b0);
        chk(seen, 5'b11101);
        chk(shadow_active, 1'b1);
        wr(pidc_pkg::ADDR_CFG_TWO, 8'h01);
        repeat (3) @(posedge clk);
        #1 chk(addr_buffer_enable_n, 1'b0);
        chk(shadow_active, 1'b0);
        rd(pidc_pkg::ADDR_CFG_TWO, 8'h01);
        rd(pidc_pkg::ADDR_CFG_ONE, 8'h00);
        wr(pidc_pkg::ADDR_CFG_ONE, 8'h01);
        rd(pidc_pkg::ADDR_CFG_ONE, 8'h01);
        acc(24'h000000, 1'b0);
        chk(seen[1:0], 2'b11);
        chk(local_addr_oe, 6'h3F);
        chk(local_addr_out, 6'h3F);
        acc(24'h000001, 1'b0);
        chk(seen[1:0], 2'b10);
        wr(pidc_pkg::ADDR_CFG_TWO, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk(addr_buffer_enable_n, 1'b1);
    endtask
    task automatic results;
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        {rst_b, reg_wr, reg_rd, go, go_wr, hold_acknowledge, addr_bit20_gate} = '0;
        {refresh_n, external_master_n, shadow_enable_n} = 3'b111;
        {wait_strap_one_or_data4, wait_strap_two_or_data5, processor_addr_bit20} = '0;
        {reg_addr, reg_wdata, refresh_addr, go_addr} = '0;
        size_strap_or_data_low = 4'h0;
        seen = 5'h00;
        n_fail = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_frst();
        t_pins();
        t_refresh();
        t_legacy();
        t_modes();
        results();
    end
    // the whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        $display("MISMATCH %0t watchdog expired", $time);
        n_fail++;
        results();
    end
endmodule

bind pidc_ctrl pidc_chk u_chk (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .cpu,
    .refresh_n, .addr_bit20_gate, .processor_addr_bit20, .gated_local_addr_bit20,
    .bank_row_strobes_n, .addr_buffer_enable_n, .memory_data_direction,
    .local_ready_n, .next_address_request_n, .fast_reset_n);
